// ### common/dmm_defines.vh
// Constants for the delta measurement mode controller.
`ifndef DMM_DEFINES_VH
`define DMM_DEFINES_VH

// Register byte addresses.
`define DMM_ADDR_CTRL    8'h00
`define DMM_ADDR_STATUS  8'h04
`define DMM_ADDR_POS     8'h08
`define DMM_ADDR_VALUE   8'h0C

// Control register fields and reset value.
`define DMM_CTRL_EN_BIT    0
`define DMM_CTRL_CLR_BIT   1
`define DMM_CTRL_RESET     1'h1

// Measurement modes.
`define DMM_MODE_NONE   2'h0
`define DMM_MODE_VOLTS  2'h1
`define DMM_MODE_TIME   2'h2
`define DMM_MODE_RECIP  2'h3

// Readout formats.
`define DMM_FMT_NONE    3'h0
`define DMM_FMT_VOLTS   3'h1
`define DMM_FMT_VPCT    3'h2
`define DMM_FMT_TIME    3'h3
`define DMM_FMT_TPCT    3'h4
`define DMM_FMT_FREQ    3'h5
`define DMM_FMT_PHASE   3'h6
`define DMM_FMT_DELAY   3'h7

// Cursor kinds.
`define DMM_CUR_NONE    2'h0
`define DMM_CUR_HORIZ   2'h1
`define DMM_CUR_VERT    2'h2
`define DMM_CUR_DELAYS  2'h3

// Frequency units.
`define DMM_UNIT_HZ     2'h0
`define DMM_UNIT_KHZ    2'h1
`define DMM_UNIT_MHZ    2'h2
`define DMM_UNIT_GHZ    2'h3

// Magnifier.
`define DMM_MAG_X1          4'h1
`define DMM_MAG_X10         4'hA
`define DMM_FASTEST_PS_X1   13'h1388
`define DMM_FASTEST_PS_X10  13'h01F4

// Positions, in hundredths of a division.
`define DMM_POS_MAX      10'h3FF
`define DMM_REF_RESET    10'h100
`define DMM_DELTA_RESET  10'h300

// Fine and coarse stepping.
`define DMM_FINE_RUN     6'h10
`define DMM_FINE_AMT     4'h1
`define DMM_COARSE_AMT   4'h8

// Five divisions are 100 percent or 360 degrees, in hundredths.
`define DMM_PCT_MUL      17'h00014
`define DMM_DEG_MUL      17'h00048

`endif

// ### hw/dmm_sync.v
// Two flip-flop synchroniser for panel inputs.
`timescale 1ns/1ps
`default_nettype none
module dmm_sync #(
  parameter W = 20
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;

  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // dmm_sync
`default_nettype wire

// ### hw/dmm_step.v
// Fine or coarse step size for one position control.
`timescale 1ns/1ps
`default_nettype none
`include "dmm_defines.vh"
module dmm_step (
  input  wire       clk,
  input  wire       rst,
  input  wire       step,
  input  wire       dir,
  output wire [3:0] amt
);
  reg [5:0] run_q;
  reg       dir_q;

  // A reversal drops back to fine steps at once.
  assign amt = (step && dir == dir_q && run_q >= `DMM_FINE_RUN) ?
               `DMM_COARSE_AMT : `DMM_FINE_AMT;

  always @(posedge clk) begin
    if (rst) begin
      run_q <= 6'h00;
      dir_q <= 1'b0;
    end else if (step) begin
      dir_q <= dir;
      if (dir != dir_q)
        run_q <= 6'h01;
      else if (run_q < `DMM_FINE_RUN)
        run_q <= run_q + 6'h01;
    end
  end
endmodule // dmm_step
`default_nettype wire

// ### hw/dmm_ctrl.v
// Delta measurement mode controller with APB registers.
`timescale 1ns/1ps
`default_nettype none
`include "dmm_defines.vh"
// Functional notes
// - Volts button alone enters volts mode, clearing other delta modes.
// - In volts mode, volts button or pulling delayed knob cancels it.
// - Volts request with knobs unlocked raises error instead of entering.
// - Error cleared by either button, knob push/pull, or locking knobs.
// - Time button alone enters time mode, clearing other delta modes.
// - In time mode, time button cancels it, leaving no mode.
// - Both buttons together enter reciprocal mode, clearing others.
// - In reciprocal mode, both buttons together exit all delta modes.
// - In reciprocal mode, one button enters that button's mode.
// - Magnifier toggles x10 per press; alternate display magnifies delayed only.
// - Volts mode on main sweep shows horizontal cursors, readout is voltage.
// - Volts scale comes from first enabled channel in display order.
// - Volts readout is percent if scale channel uncal or sum shown alone with unequal deflection.
// - Locked knobs, time or reciprocal mode show two vertical cursors.
// - Delayed displays use two independent delays, readout their difference.
// - Main sweep with variable uncal gives time ratio, five divisions 100%.
// - In delayed displays variable changes delayed scale only, not readout.
// - Reciprocal readout is frequency in Hz, kHz, MHz or GHz.
// - Reciprocal, main sweep, variable uncal reads phase, five divisions 360.
// - Linked mode: reference control moves both, difference kept, until a limit.
// - Separate mode: each control moves only its own position.
// - Delta control always moves only the delta position.
// - Position controls step fine, then coarse; reversal returns to fine.
// - Pulling knob cancels volts mode; pushing in clears the error.
module dmm_ctrl (
  input  wire        REF_CLK,
  input  wire        RESET,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire        BTN_VOLTS,
  input  wire        BTN_TIME,
  input  wire        BTN_MAG,
  input  wire        DELAYED_KNOB_OUT,
  input  wire        KNOBS_SAME_SPEED,
  input  wire        ALT_DISPLAY,
  input  wire        VAR_SWEEP_UNCAL,
  input  wire [4:0]  CHAN_ON,
  input  wire [4:0]  CHAN_UNCAL,
  input  wire        DEFL_EQUAL_12,
  input  wire        LINKED_CURSOR,
  input  wire        REF_STEP,
  input  wire        REF_DIR,
  input  wire        DELTA_STEP,
  input  wire        DELTA_DIR,
  input  wire [3:0]  TIME_DECADE,
  output reg  [1:0]  MEAS_MODE,
  output reg         ERR_MSG,
  output reg         MAG_MAIN,
  output reg         MAG_DELAYED,
  output reg  [3:0]  MAG_FACTOR,
  output reg  [12:0] FASTEST_PS,
  output reg  [1:0]  CURSOR_KIND,
  output reg  [2:0]  SCALE_CHAN,
  output reg  [2:0]  READOUT_FMT,
  output reg  [1:0]  FREQ_UNIT,
  output reg  [16:0] READOUT_VALUE,
  output reg  [9:0]  REF_POS,
  output reg  [9:0]  DELTA_POS,
  output reg         VAR_ON_DELAYED
);

  // Channel order is CH1, CH2, sum, CH3, CH4; index 5 means none enabled.
  function [2:0] first_chan;
    input [4:0] on;
    begin
      if (on[0])
        first_chan = 3'h0;
      else if (on[1])
        first_chan = 3'h1;
      else if (on[2])
        first_chan = 3'h2;
      else if (on[3])
        first_chan = 3'h3;
      else if (on[4])
        first_chan = 3'h4;
      else
        first_chan = 3'h5;
    end
  endfunction

  function [1:0] unit_of;
    input [3:0] dec;
    begin
      if (dec < 4'h3)
        unit_of = `DMM_UNIT_HZ;
      else if (dec < 4'h6)
        unit_of = `DMM_UNIT_KHZ;
      else if (dec < 4'h9)
        unit_of = `DMM_UNIT_MHZ;
      else
        unit_of = `DMM_UNIT_GHZ;
    end
  endfunction

  // True when moving pos by amt in direction dir stays inside the travel.
  function fits;
    input [9:0] pos;
    input [3:0] amt;
    input       dir;
    reg   [10:0] sum;
    begin
      sum = {1'b0, pos} + {7'h00, amt};
      if (dir)
        fits = (sum[10] == 1'b0);
      else
        fits = (pos >= {6'h00, amt});
    end
  endfunction

  function [9:0] moved;
    input [9:0] pos;
    input [3:0] amt;
    input       dir;
    begin
      if (dir)
        moved = pos + {6'h00, amt};
      else
        moved = pos - {6'h00, amt};
    end
  endfunction

  // Panel pins cross into this clock through two flops.
  wire [19:0] pin_s;
  dmm_sync #(.W(20)) u_sync (
    .clk (REF_CLK),
    .rst (RESET),
    .d   ({BTN_VOLTS, BTN_TIME, BTN_MAG, DELAYED_KNOB_OUT, KNOBS_SAME_SPEED,
           ALT_DISPLAY, VAR_SWEEP_UNCAL, DEFL_EQUAL_12, LINKED_CURSOR,
           REF_STEP, REF_DIR, DELTA_STEP, DELTA_DIR, CHAN_ON, CHAN_UNCAL[0],
           CHAN_UNCAL[1]}),
    .q   (pin_s)
  );

  wire dv_s     = pin_s[19];
  wire dt_s     = pin_s[18];
  wire mag_s    = pin_s[17];
  wire kout_s   = pin_s[16];
  wire same_s   = pin_s[15];
  wire alt_s    = pin_s[14];
  wire var_s    = pin_s[13];
  wire equ_s    = pin_s[12];
  wire link_s   = pin_s[11];
  wire rstep_s  = pin_s[10];
  wire rdir_s   = pin_s[9];
  wire dstep_s  = pin_s[8];
  wire ddir_s   = pin_s[7];
  wire [4:0] on_s = pin_s[6:2];

  // Uncal flags of channels 3, 4 and the sum come through a second synchroniser.
  wire [2:0] uncal_hi_s;
  reg  [4:0] uncal_s;
  dmm_sync #(.W(3)) u_sync_uncal (
    .clk (REF_CLK),
    .rst (RESET),
    .d   (CHAN_UNCAL[4:2]),
    .q   (uncal_hi_s)
  );
  always @* begin
    uncal_s = {uncal_hi_s, pin_s[0], pin_s[1]};
  end

  // The time decade is a panel level as well, so it gets the same two flops.
  wire [3:0] dec_s;
  dmm_sync #(.W(4)) u_sync_dec (
    .clk (REF_CLK),
    .rst (RESET),
    .d   (TIME_DECADE),
    .q   (dec_s)
  );

  wire locked_s = same_s & ~kout_s;

  // Edge history of synchronised levels.
  reg mag_q, kout_q, locked_q, rstep_q, dstep_q;
  always @(posedge REF_CLK) begin
    if (RESET) begin
      mag_q    <= 1'b0;
      kout_q   <= 1'b0;
      locked_q <= 1'b1;
      rstep_q  <= 1'b0;
      dstep_q  <= 1'b0;
    end else begin
      mag_q    <= mag_s;
      kout_q   <= kout_s;
      locked_q <= locked_s;
      rstep_q  <= rstep_s;
      dstep_q  <= dstep_s;
    end
  end

  wire mag_press   = mag_s & ~mag_q;
  wire knob_pull   = kout_s & ~kout_q;
  wire knob_toggle = kout_s ^ kout_q;
  wire lock_rise   = locked_s & ~locked_q;
  wire ref_step    = rstep_s & ~rstep_q;
  wire delta_step  = dstep_s & ~dstep_q;

  // APB registers.
  reg  ctrl_en_q;
  wire wr_en  = PSEL & PENABLE & PWRITE;
  wire mapped = (PADDR == `DMM_ADDR_CTRL) | (PADDR == `DMM_ADDR_STATUS) |
                (PADDR == `DMM_ADDR_POS) | (PADDR == `DMM_ADDR_VALUE);
  wire clr_cmd = wr_en & (PADDR == `DMM_ADDR_CTRL) & PWDATA[`DMM_CTRL_CLR_BIT];

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // Read data is captured in the setup phase so the access phase needs no wait.
  always @(posedge REF_CLK) begin
    if (RESET) begin
      ctrl_en_q <= `DMM_CTRL_RESET;
      PRDATA    <= 32'h00000000;
    end else begin
      if (wr_en && PADDR == `DMM_ADDR_CTRL)
        ctrl_en_q <= PWDATA[`DMM_CTRL_EN_BIT];
      if (PSEL && !PENABLE && !PWRITE) begin
        case (PADDR)
          `DMM_ADDR_CTRL:   PRDATA <= {31'h00000000, ctrl_en_q};
          `DMM_ADDR_STATUS: PRDATA <= {12'h000, SCALE_CHAN, FREQ_UNIT,
                                       READOUT_FMT, CURSOR_KIND, MAG_FACTOR,
                                       MAG_DELAYED, MAG_MAIN, ERR_MSG, 1'h0,
                                       MEAS_MODE};
          `DMM_ADDR_POS:    PRDATA <= {6'h00, DELTA_POS, 6'h00, REF_POS};
          `DMM_ADDR_VALUE:  PRDATA <= {15'h0000, READOUT_VALUE};
          default:          PRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // Button gestures are decided on release, so a two-button press that does
  // not land in the same cycle is still seen as a pair.
  reg  [1:0] held_q, held_d;
  wire       any_btn = dv_s | dt_s;
  wire       gesture = ~any_btn & (held_q != 2'h0);
  always @* begin
    held_d = held_q;
    if (!ctrl_en_q)
      held_d = 2'h0;
    else if (any_btn)
      held_d = held_q | {dt_s, dv_s};
    else
      held_d = 2'h0;
  end

  reg [1:0] mode_d;
  reg       err_d;
  reg       err_set;
  always @* begin
    mode_d  = MEAS_MODE;
    err_d   = ERR_MSG;
    err_set = 1'b0;
    // A panel gesture landing with a software clear wins, so no press is lost.
    if (clr_cmd && !gesture) begin
      mode_d = `DMM_MODE_NONE;
      err_d  = 1'b0;
    end else begin
      if (gesture) begin
        case (held_q)
          2'h3: begin
            err_d  = 1'b0;
            if (MEAS_MODE == `DMM_MODE_RECIP)
              mode_d = `DMM_MODE_NONE;
            else
              mode_d = `DMM_MODE_RECIP;
          end
          2'h1: begin
            if (MEAS_MODE == `DMM_MODE_VOLTS) begin
              mode_d = `DMM_MODE_NONE;
              err_d  = 1'b0;
            end else if (!locked_s) begin
              // A press while the message shows only removes it.
              err_set = ~ERR_MSG;
              err_d   = ~ERR_MSG;
            end else begin
              mode_d = `DMM_MODE_VOLTS;
              err_d  = 1'b0;
            end
          end
          2'h2: begin
            err_d = 1'b0;
            if (MEAS_MODE == `DMM_MODE_TIME)
              mode_d = `DMM_MODE_NONE;
            else
              mode_d = `DMM_MODE_TIME;
          end
          default: begin
            err_d = ERR_MSG;
          end
        endcase
      end
      if (knob_pull && mode_d == `DMM_MODE_VOLTS)
        mode_d = `DMM_MODE_NONE;
      if ((knob_toggle || lock_rise) && !err_set)
        err_d = 1'b0;
    end
  end

  // Position controls.
  wire [3:0] ref_amt, delta_amt;
  dmm_step u_ref_step (
    .clk  (REF_CLK),
    .rst  (RESET),
    .step (ref_step),
    .dir  (rdir_s),
    .amt  (ref_amt)
  );
  dmm_step u_delta_step (
    .clk  (REF_CLK),
    .rst  (RESET),
    .step (delta_step),
    .dir  (ddir_s),
    .amt  (delta_amt)
  );

  reg [9:0] ref_d, delta_d;
  always @* begin
    ref_d   = REF_POS;
    delta_d = DELTA_POS;
    if (ref_step) begin
      if (link_s) begin
        // Both move or neither, so the difference never drifts at a stop.
        if (fits(REF_POS, ref_amt, rdir_s) && fits(DELTA_POS, ref_amt, rdir_s)) begin
          ref_d   = moved(REF_POS, ref_amt, rdir_s);
          delta_d = moved(DELTA_POS, ref_amt, rdir_s);
        end
      end else if (fits(REF_POS, ref_amt, rdir_s)) begin
        ref_d = moved(REF_POS, ref_amt, rdir_s);
      end
    end
    if (delta_step && fits(delta_d, delta_amt, ddir_s))
      delta_d = moved(delta_d, delta_amt, ddir_s);
  end

  // Readout selection.
  wire [2:0]  chan_d   = first_chan(on_s);
  wire        sum_only = (on_s == 5'h04);
  wire        scale_uc = (chan_d < 3'h5) ? uncal_s[chan_d] : 1'b0;
  wire        delayed  = ~locked_s;
  wire [9:0]  abs_diff = (DELTA_POS >= REF_POS) ? (DELTA_POS - REF_POS) :
                                                  (REF_POS - DELTA_POS);
  reg  [2:0]  fmt_d;
  reg  [1:0]  cur_d;
  reg  [16:0] value_d;
  always @* begin
    fmt_d = `DMM_FMT_NONE;
    cur_d = `DMM_CUR_NONE;
    case (MEAS_MODE)
      `DMM_MODE_VOLTS: begin
        if (locked_s)
          cur_d = `DMM_CUR_HORIZ;
        if (scale_uc || (sum_only && !equ_s))
          fmt_d = `DMM_FMT_VPCT;
        else
          fmt_d = `DMM_FMT_VOLTS;
      end
      `DMM_MODE_TIME: begin
        if (delayed) begin
          cur_d = `DMM_CUR_DELAYS;
          fmt_d = `DMM_FMT_DELAY;
        end else begin
          cur_d = `DMM_CUR_VERT;
          fmt_d = var_s ? `DMM_FMT_TPCT : `DMM_FMT_TIME;
        end
      end
      `DMM_MODE_RECIP: begin
        cur_d = delayed ? `DMM_CUR_DELAYS : `DMM_CUR_VERT;
        fmt_d = (!delayed && var_s) ? `DMM_FMT_PHASE : `DMM_FMT_FREQ;
      end
      default: begin
        fmt_d = `DMM_FMT_NONE;
      end
    endcase
    if (fmt_d == `DMM_FMT_TPCT)
      value_d = {7'h00, abs_diff} * `DMM_PCT_MUL;
    else if (fmt_d == `DMM_FMT_PHASE)
      value_d = {7'h00, abs_diff} * `DMM_DEG_MUL;
    else
      value_d = {7'h00, abs_diff};
  end

  // Magnifier; in alternate display only the delayed trace is enlarged.
  reg mag_on_q;
  always @(posedge REF_CLK) begin
    if (RESET) begin
      held_q         <= 2'h0;
      MEAS_MODE      <= `DMM_MODE_NONE;
      ERR_MSG        <= 1'b0;
      mag_on_q       <= 1'b0;
      MAG_MAIN       <= 1'b0;
      MAG_DELAYED    <= 1'b0;
      MAG_FACTOR     <= `DMM_MAG_X1;
      FASTEST_PS     <= `DMM_FASTEST_PS_X1;
      CURSOR_KIND    <= `DMM_CUR_NONE;
      SCALE_CHAN     <= 3'h5;
      READOUT_FMT    <= `DMM_FMT_NONE;
      FREQ_UNIT      <= `DMM_UNIT_HZ;
      READOUT_VALUE  <= 17'h00000;
      REF_POS        <= `DMM_REF_RESET;
      DELTA_POS      <= `DMM_DELTA_RESET;
      VAR_ON_DELAYED <= 1'b0;
    end else begin
      held_q    <= held_d;
      MEAS_MODE <= mode_d;
      ERR_MSG   <= err_d;
      if (mag_press && ctrl_en_q)
        mag_on_q <= ~mag_on_q;
      MAG_MAIN       <= mag_on_q & ~alt_s;
      MAG_DELAYED    <= mag_on_q;
      MAG_FACTOR     <= mag_on_q ? `DMM_MAG_X10 : `DMM_MAG_X1;
      FASTEST_PS     <= mag_on_q ? `DMM_FASTEST_PS_X10 : `DMM_FASTEST_PS_X1;
      CURSOR_KIND    <= cur_d;
      SCALE_CHAN     <= chan_d;
      READOUT_FMT    <= fmt_d;
      FREQ_UNIT      <= unit_of(dec_s);
      READOUT_VALUE  <= value_d;
      REF_POS        <= ref_d;
      DELTA_POS      <= delta_d;
      VAR_ON_DELAYED <= delayed;
    end
  end

endmodule // dmm_ctrl
`default_nettype wire

// ### tb/dmm_ctrl_assertions.sv
// Concurrent checks on the ports of the delta measurement controller.
`timescale 1ns/1ps
`default_nettype none
`include "dmm_defines.vh"
module dmm_ctrl_assertions (
  input wire logic        REF_CLK,
  input wire logic        RESET,
  input wire logic        DELAYED_KNOB_OUT,
  input wire logic        KNOBS_SAME_SPEED,
  input wire logic        LINKED_CURSOR,
  input wire logic        REF_STEP,
  input wire logic        DELTA_STEP,
  input wire logic [1:0]  MEAS_MODE,
  input wire logic        ERR_MSG,
  input wire logic [3:0]  MAG_FACTOR,
  input wire logic [12:0] FASTEST_PS,
  input wire logic [1:0]  CURSOR_KIND,
  input wire logic [9:0]  REF_POS,
  input wire logic [9:0]  DELTA_POS
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  // Panel levels pass two sampling stages and an output stage, so a level
  // must have stood five edges before its effect is judged.
  wire locked = KNOBS_SAME_SPEED && !DELAYED_KNOB_OUT;
  sequence s_linked_quiet;
    (LINKED_CURSOR && !DELTA_STEP) [*6];
  endsequence
  sequence s_separate_quiet;
    (!LINKED_CURSOR && !DELTA_STEP) [*6];
  endsequence
  a_reset_clean: assert property (disable iff (1'h0) RESET [*2] |=>
    MEAS_MODE == `DMM_MODE_NONE && !ERR_MSG && MAG_FACTOR == `DMM_MAG_X1)
    else $error("outputs not idle after reset");
  a_err_no_volts: assert property ($rose(ERR_MSG) |-> MEAS_MODE != `DMM_MODE_VOLTS)
    else $error("volts mode entered with error shown");
  a_mag_speed: assert property ($changed(MAG_FACTOR) |-> ##[0:1]
    FASTEST_PS == (MAG_FACTOR == `DMM_MAG_X10 ? `DMM_FASTEST_PS_X10 : `DMM_FASTEST_PS_X1))
    else $error("fastest sweep does not follow magnifier");
  a_volts_horiz: assert property ((MEAS_MODE == `DMM_MODE_VOLTS && locked) [*5] |->
    CURSOR_KIND == `DMM_CUR_HORIZ)
    else $error("volts mode without horizontal cursors");
  a_delay_pair: assert property ((MEAS_MODE[1] && DELAYED_KNOB_OUT) [*5] |->
    CURSOR_KIND == `DMM_CUR_DELAYS)
    else $error("time mode in delayed display without two delays");
  a_link_diff: assert property (s_linked_quiet ##0 $changed(REF_POS) |->
    (DELTA_POS - $past(DELTA_POS)) == (REF_POS - $past(REF_POS)))
    else $error("linked positions did not move equally");
  a_sep_delta: assert property (s_separate_quiet |-> $stable(DELTA_POS))
    else $error("delta position moved without its control");
  a_ref_own: assert property ((!REF_STEP) [*6] |-> $stable(REF_POS))
    else $error("reference position moved without its control");
  a_step_size: assert property ($changed(REF_POS) |-> (REF_POS - $past(REF_POS))
    inside {10'h001, 10'h3FF, 10'h008, 10'h3F8})
    else $error("reference step size is neither fine nor coarse");
endmodule // dmm_ctrl_assertions
bind dmm_ctrl dmm_ctrl_assertions u_chk (
  .REF_CLK(REF_CLK), .RESET(RESET), .DELAYED_KNOB_OUT(DELAYED_KNOB_OUT),
  .KNOBS_SAME_SPEED(KNOBS_SAME_SPEED), .LINKED_CURSOR(LINKED_CURSOR),
  .REF_STEP(REF_STEP), .DELTA_STEP(DELTA_STEP), .MEAS_MODE(MEAS_MODE),
  .ERR_MSG(ERR_MSG), .MAG_FACTOR(MAG_FACTOR), .FASTEST_PS(FASTEST_PS),
  .CURSOR_KIND(CURSOR_KIND), .REF_POS(REF_POS), .DELTA_POS(DELTA_POS)
);
`default_nettype wire

// ### tb/dmm_panel.sv
// Front-panel model: delta buttons, magnifier, sweep knobs, encoders.
`timescale 1ns/1ps
`default_nettype none
module dmm_panel (
  input  wire logic clk,
  output logic      btn_volts,
  output logic      btn_time,
  output logic      btn_mag,
  output logic      knob_out,
  output logic      same_speed,
  output logic      ref_step,
  output logic      ref_dir,
  output logic      delta_step,
  output logic      delta_dir
);
  initial begin
    btn_volts = 1'h0;
    btn_time = 1'h0;
    btn_mag = 1'h0;
    knob_out = 1'h0;
    same_speed = 1'h1;
    ref_step = 1'h0;
    ref_dir = 1'h0;
    delta_step = 1'h0;
    delta_dir = 1'h0;
  end
  // Buttons are released together so the held combination is unambiguous.
  task automatic press(input logic v, input logic t, input logic m);
    @(posedge clk);
    btn_volts <= v;
    btn_time <= t;
    btn_mag <= m;
    repeat (4) @(posedge clk);
    btn_volts <= 1'h0;
    btn_time <= 1'h0;
    btn_mag <= 1'h0;
    repeat (8) @(posedge clk);
  endtask
  task automatic knobs(input logic o, input logic s);
    @(posedge clk);
    knob_out <= o;
    same_speed <= s;
    repeat (8) @(posedge clk);
  endtask
  // Direction settles an edge before the step so it is never sampled late.
  task automatic step(input logic r, input logic d);
    @(posedge clk);
    if (r) ref_dir <= d;
    else delta_dir <= d;
    @(posedge clk);
    if (r) ref_step <= 1'h1;
    else delta_step <= 1'h1;
    repeat (3) @(posedge clk);
    ref_step <= 1'h0;
    delta_step <= 1'h0;
    repeat (6) @(posedge clk);
  endtask
endmodule // dmm_panel
`default_nettype wire

// ### tb/dmm_ctrl_tb.sv
// Self-checking bench for the delta measurement controller.
`timescale 1ns/1ps
`default_nettype none
`include "dmm_defines.vh"
module dmm_ctrl_tb;
  logic        clk, rst, psel, penable, pwrite, alt, var_uncal, defl_eq, linked, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rdat;
  logic [4:0]  chan_on, chan_uncal;
  logic [3:0]  decade;
  wire         bv, bt, bm, kout, same, rs, rd, ds, dd, pready, pslverr;
  wire         err_msg, mag_main, mag_del, var_del;
  wire  [31:0] prdata;
  wire  [1:0]  mode, cur, unit;
  wire  [3:0]  magf;
  wire  [12:0] fast;
  wire  [2:0]  sch, fmt;
  wire  [16:0] value;
  wire  [9:0]  refp, delp;
  int          miscompares, check_count, cycles;
  dmm_ctrl u_dut (
    .REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BTN_VOLTS(bv), .BTN_TIME(bt), .BTN_MAG(bm),
    .DELAYED_KNOB_OUT(kout), .KNOBS_SAME_SPEED(same), .ALT_DISPLAY(alt),
    .VAR_SWEEP_UNCAL(var_uncal), .CHAN_ON(chan_on), .CHAN_UNCAL(chan_uncal),
    .DEFL_EQUAL_12(defl_eq), .LINKED_CURSOR(linked), .REF_STEP(rs), .REF_DIR(rd),
    .DELTA_STEP(ds), .DELTA_DIR(dd), .TIME_DECADE(decade), .MEAS_MODE(mode),
    .ERR_MSG(err_msg), .MAG_MAIN(mag_main), .MAG_DELAYED(mag_del),
    .MAG_FACTOR(magf), .FASTEST_PS(fast), .CURSOR_KIND(cur), .SCALE_CHAN(sch),
    .READOUT_FMT(fmt), .FREQ_UNIT(unit), .READOUT_VALUE(value), .REF_POS(refp),
    .DELTA_POS(delp), .VAR_ON_DELAYED(var_del)
  );
  dmm_panel u_panel (
    .clk(clk), .btn_volts(bv), .btn_time(bt), .btn_mag(bm), .knob_out(kout),
    .same_speed(same), .ref_step(rs), .ref_dir(rd), .delta_step(ds), .delta_dir(dd)
  );
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic end_sim;
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      end_sim;
    end
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic t_reset;
    chk("mode", mode, `DMM_MODE_NONE);
    chk("err", err_msg, 1'h0);
    chk("fast", fast, `DMM_FASTEST_PS_X1);
    apb(1'h0, `DMM_ADDR_STATUS, 32'h0);
    chk("status", rdat, 32'h000A0040);
    apb(1'h0, `DMM_ADDR_POS, 32'h0);
    chk("pos", rdat, 32'h03000100);
    apb(1'h0, 8'h10, 32'h0);
    chk("slverr", rerr, 1'h1);
    chk("unmapped", rdat, 32'h0);
  endtask
  task automatic t_ctrl;
    apb(1'h1, `DMM_ADDR_CTRL, 32'h0);
    u_panel.press(1'h0, 1'h1, 1'h0);
    chk("mode", mode, `DMM_MODE_NONE);
    apb(1'h1, `DMM_ADDR_CTRL, 32'h1);
    u_panel.press(1'h0, 1'h1, 1'h0);
    apb(1'h1, `DMM_ADDR_CTRL, 32'h3);
    apb(1'h0, `DMM_ADDR_CTRL, 32'h0);
    chk("ctrl", rdat, 32'h1);
    chk("mode", mode, `DMM_MODE_NONE);
  endtask
  // Gestures as {volts, time} pairs and the mode each must leave behind.
  task automatic t_modes;
    logic [21:0] g;
    logic [21:0] e;
    g = 22'h1B7A5F;
    e = 22'h27B48C;
    for (int i = 10; i >= 0; i--) begin
      u_panel.press(g[2*i+1], g[2*i], 1'h0);
      chk("mode", mode, e[2*i +: 2]);
    end
  endtask
  task automatic t_err;
    u_panel.press(1'h1, 1'h0, 1'h0);
    u_panel.knobs(1'h1, 1'h1);
    chk("mode", mode, `DMM_MODE_NONE);
    u_panel.press(1'h1, 1'h0, 1'h0);
    chk("err", err_msg, 1'h1);
    chk("mode", mode, `DMM_MODE_NONE);
    u_panel.knobs(1'h0, 1'h0);
    chk("err", err_msg, 1'h0);
    u_panel.press(1'h1, 1'h0, 1'h0);
    chk("err", err_msg, 1'h1);
    u_panel.knobs(1'h0, 1'h1);
    chk("err", err_msg, 1'h0);
    u_panel.knobs(1'h0, 1'h0);
    u_panel.press(1'h1, 1'h0, 1'h0);
    u_panel.knobs(1'h1, 1'h0);
    chk("err", err_msg, 1'h0);
    u_panel.press(1'h1, 1'h0, 1'h0);
    u_panel.press(1'h0, 1'h1, 1'h0);
    chk("err", err_msg, 1'h0);
    u_panel.knobs(1'h0, 1'h1);
    apb(1'h1, `DMM_ADDR_CTRL, 32'h3);
  endtask
  task automatic t_mag;
    u_panel.press(1'h0, 1'h0, 1'h1);
    chk("magf", magf, `DMM_MAG_X10);
    chk("main", mag_main, 1'h1);
    alt <= 1'h1;
    wt(8);
    chk("main", mag_main, 1'h0);
    chk("delayed", mag_del, 1'h1);
    alt <= 1'h0;
    u_panel.press(1'h0, 1'h0, 1'h1);
    chk("magf", magf, `DMM_MAG_X1);
  endtask
  task automatic t_read;
    chan_on <= 5'h0A;
    u_panel.press(1'h1, 1'h0, 1'h0);
    chk("chan", sch, 3'h1);
    chk("fmt", fmt, `DMM_FMT_VOLTS);
    chan_uncal <= 5'h02;
    wt(8);
    chk("fmt", fmt, `DMM_FMT_VPCT);
    chan_uncal <= 5'h00;
    chan_on <= 5'h04;
    defl_eq <= 1'h0;
    wt(8);
    chk("fmt", fmt, `DMM_FMT_VPCT);
    u_panel.press(1'h0, 1'h1, 1'h0);
    chk("cursor", cur, `DMM_CUR_VERT);
    var_uncal <= 1'h1;
    wt(8);
    chk("value", value, 17'h02800);
    u_panel.press(1'h1, 1'h1, 1'h0);
    chk("value", value, 17'h09000);
    var_uncal <= 1'h0;
    decade <= 4'h4;
    wt(8);
    chk("unit", unit, `DMM_UNIT_KHZ);
    var_uncal <= 1'h1;
    u_panel.knobs(1'h1, 1'h1);
    chk("fmt", fmt, `DMM_FMT_FREQ);
    chk("var", var_del, 1'h1);
    u_panel.press(1'h0, 1'h1, 1'h0);
    chk("fmt", fmt, `DMM_FMT_DELAY);
    u_panel.knobs(1'h0, 1'h1);
    apb(1'h1, `DMM_ADDR_CTRL, 32'h3);
  endtask
  task automatic t_pos;
    for (int i = 0; i < 17; i++)
      u_panel.step(1'h1, 1'h1);
    chk("ref", refp, 10'h118);
    u_panel.step(1'h1, 1'h0);
    chk("ref", refp, 10'h117);
    u_panel.step(1'h0, 1'h1);
    chk("delta", delp, 10'h301);
    linked <= 1'h1;
    u_panel.step(1'h1, 1'h1);
    chk("delta", delp, 10'h302);
  endtask
  initial begin
    {miscompares, check_count, cycles} = '0;
    {rst, defl_eq} = 2'h3;
    {psel, penable, pwrite, alt, var_uncal, linked} = 6'h00;
    {paddr, pwdata, chan_on, chan_uncal, decade} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    t_reset;
    t_ctrl;
    t_modes;
    t_err;
    t_mag;
    t_read;
    t_pos;
    end_sim;
  end
endmodule // dmm_ctrl_tb
`default_nettype wire
